// ===== pkg/flash_spi_regs.svh
`ifndef FLASH_SPI_REGS_SVH
`define FLASH_SPI_REGS_SVH

// Default opcodes for the four read commands; only dual and quad turn lanes around
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_READ 8'h3b
`define OP_QUAD_READ 8'h6b

// Input bits before the data phase: command plus 24 address bits
`define LEAD_PLAIN 6'h20
// Same plus one dummy byte for the fast reads
`define LEAD_DUMMY 6'h28
// Saturation value of the input bit counter
`define LEAD_MAX 6'h3f

// Byte shifted out when the read stream runs dry
`define FILL_BYTE 8'hff
// Bits per byte on the output shifter
`define BYTE_BITS 4'h8

// Read data buffer depth
`define FIFO_DEPTH 16

// Synchroniser reset: hold_n, wp_n high, si and sck low, cs_n high
`define SYNC_RESET 5'h19

`endif

// ===== pkg/flash_spi_pkg.sv
package flash_spi_pkg;

  // Lane use during a read data phase
  typedef enum logic [1:0] {
    LANE_NONE = 2'b00,
    LANE_ONE = 2'b01,
    LANE_TWO = 2'b10,
    LANE_FOUR = 2'b11
  } lane_t;

  // Frame phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_IN = 2'b01,
    PH_OUT = 2'b10
  } phase_t;

endpackage : flash_spi_pkg

// ===== src/stream_fifo.sv
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  // Handshake decode
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Storage, written only on a push
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the last slot, so any depth works
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : stream_fifo

// ===== src/flash_spi_front_end.sv
`timescale 1ns/1ps
`include "flash_spi_regs.svh"
// Overview of operation
// - Works with serial clock idling low or high, same sampling edges.
// - Operation starts on select falling and ends on select rising.
// - Deselected: standby, never deep power-down, serial output floats.
// - Deselected: data input ignored, nothing captured.
// - Standby entry waits for any running program or erase cycle.
// - Command, address and write bits sampled on serial clock rise.
// - Read data changes only on serial clock fall.
// - Command, address and write data come one bit at a time on input.
// - Multi-lane reads turn the input pin into output lane zero.
// - Two-lane reads drive output pin as lane one with lane zero.
// - Four-lane reads drive protect pin as lane two, hold as three.
// - Pause starts selected with clock low, except in a quad read data phase; ignores clock, floats output.
// - Pause stops only the link; internal cycles keep running.
module flash_spi_front_end
  import flash_spi_pkg::*;
#(
  parameter logic [7:0] OP_READ = `OP_READ,
  parameter logic [7:0] OP_FAST_READ = `OP_FAST_READ,
  parameter logic [7:0] OP_DUAL_READ = `OP_DUAL_READ,
  parameter logic [7:0] OP_QUAD_READ = `OP_QUAD_READ,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Select and serial clock pins
  input wire logic cs_n,
  input wire logic sck,
  // Serial input pin, lane zero
  input wire logic si_in,
  output logic si_out,
  output logic si_oe,
  // Serial output pin, lane one
  input wire logic so_in,
  output logic so_out,
  output logic so_oe,
  // Write protect pin, lane two
  input wire logic wp_n_in,
  output logic wp_n_out,
  output logic wp_n_oe,
  // Hold pin, lane three
  input wire logic hold_n_in,
  output logic hold_n_out,
  output logic hold_n_oe,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_is_cmd,
  // Read data stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Engine status
  input wire logic engine_busy,
  output logic standby,
  output logic wp_level,
  output logic link_paused
);

  // Lanes that a read opcode uses
  function automatic lane_t decode_lanes(input logic [7:0] op);
    if (op == OP_READ || op == OP_FAST_READ) begin
      return LANE_ONE;
    end else if (op == OP_DUAL_READ) begin
      return LANE_TWO;
    end else if (op == OP_QUAD_READ) begin
      return LANE_FOUR;
    end
    return LANE_NONE;
  endfunction : decode_lanes

  // Pins driven during a data phase, bit 3 hold down to bit 0 input
  function automatic logic [3:0] lane_mask(input lane_t l);
    unique case (l)
      LANE_ONE: return 4'h2;
      LANE_TWO: return 4'h3;
      LANE_FOUR: return 4'hf;
      LANE_NONE: return 4'h0;
    endcase
  endfunction : lane_mask

  // Most significant bits of the byte onto the lanes
  function automatic logic [3:0] lane_pick(input logic [7:0] b, input lane_t l);
    unique case (l)
      LANE_ONE: return {2'h0, b[7], 1'b0};
      LANE_TWO: return {2'h0, b[7:6]};
      LANE_FOUR: return b[7:4];
      LANE_NONE: return 4'h0;
    endcase
  endfunction : lane_pick

  // Two-flop synchronisers: hold, protect, input, clock, select
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= `SYNC_RESET;
      sync2 <= `SYNC_RESET;
    end else begin
      sync1 <= {hold_n_in, wp_n_in, si_in, sck, cs_n};
      sync2 <= sync1;
    end
  end

  wire cs_s = sync2[0];
  wire sck_s = sync2[1];
  wire si_s = sync2[2];
  wire hold_s = sync2[4];
  wire selected = !cs_s;

  // Frame and shifter state
  phase_t phase;
  lane_t lane;
  logic sck_prev;
  logic paused;
  logic cmd_seen;
  logic [5:0] bit_cnt;
  logic [5:0] lead;
  logic [2:0] byte_bit;
  logic [7:0] in_sh;
  logic [7:0] out_sh;
  logic [3:0] out_left;
  logic [3:0] lane_out;
  logic lanes_on;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // Edges count only while selected and not paused; either idle level works
  wire sck_rise = selected && !paused && sck_s && !sck_prev;
  wire sck_fall = selected && !paused && !sck_s && sck_prev;

  // Input side decode
  wire capture = sck_rise && (phase != PH_OUT);
  wire [7:0] in_byte = {in_sh[6:0], si_s};
  wire byte_done = capture && (byte_bit == 3'h7);
  wire [5:0] next_bit_cnt = (bit_cnt == `LEAD_MAX) ? bit_cnt : bit_cnt + 6'h1;
  wire go_out = capture && cmd_seen && (lane != LANE_NONE) && (next_bit_cnt == lead);

  // Output side decode; an empty stream sends the fill byte
  wire need_byte = (out_left == 4'h0);
  wire fetch = sck_fall && (phase == PH_OUT) && need_byte;
  wire [7:0] cur_byte = !need_byte ? out_sh : (fifo_valid ? fifo_data : `FILL_BYTE);
  wire [3:0] width = (lane == LANE_FOUR) ? 4'h4 : ((lane == LANE_TWO) ? 4'h2 : 4'h1);
  wire [3:0] next_left = (need_byte ? `BYTE_BITS : out_left) - width;

  // Hold pin doubles as lane three in the quad read data phase, so no pause there
  wire quad_out = (phase == PH_OUT) && (lane == LANE_FOUR);
  wire pause_start = selected && !hold_s && !sck_s && !quad_out;
  wire pause_end = hold_s || !selected;

  // Serial clock edge history, read from the second flop only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
    end
  end

  // Pause tracking
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      paused <= 1'b0;
    end else if (pause_start) begin
      paused <= 1'b1;
    end else if (pause_end) begin
      paused <= 1'b0;
    end
  end

  // Frame phase; deselect always returns to idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
    end else if (!selected) begin
      phase <= PH_IDLE;
    end else if (phase == PH_IDLE) begin
      phase <= PH_IN;
    end else if (go_out) begin
      phase <= PH_OUT;
    end
  end

  // Bit counting and command decode, cleared per frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 6'h0;
      byte_bit <= 3'h0;
      cmd_seen <= 1'b0;
      lane <= LANE_NONE;
      lead <= `LEAD_MAX;
      in_sh <= 8'h0;
    end else if (!selected) begin
      bit_cnt <= 6'h0;
      byte_bit <= 3'h0;
      cmd_seen <= 1'b0;
      lane <= LANE_NONE;
      lead <= `LEAD_MAX;
    end else if (capture) begin
      bit_cnt <= next_bit_cnt;
      byte_bit <= byte_bit + 3'h1;
      in_sh <= in_byte;
      if (byte_done && !cmd_seen) begin
        cmd_seen <= 1'b1;
        lane <= decode_lanes(in_byte);
        lead <= (in_byte == OP_READ) ? `LEAD_PLAIN : `LEAD_DUMMY; // Fast reads add a dummy byte
      end
    end
  end

  // Received byte stream, one-cycle valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h0;
      rx_is_cmd <= 1'b0;
    end else begin
      rx_valid <= byte_done;
      if (byte_done) begin
        rx_data <= in_byte;
        rx_is_cmd <= !cmd_seen;
      end
    end
  end

  // Output shifter moves only on falling edges; pins turn around at the first one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh <= 8'h0;
      out_left <= 4'h0;
      lane_out <= 4'h0;
      lanes_on <= 1'b0;
    end else if (!selected) begin
      out_left <= 4'h0;
      lanes_on <= 1'b0;
    end else if (sck_fall && (phase == PH_OUT)) begin
      lane_out <= lane_pick(cur_byte, lane);
      out_sh <= cur_byte << width;
      out_left <= next_left;
      lanes_on <= 1'b1;
    end
  end

  // Read stream buffer; drained one byte per output byte
  stream_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fetch),
    .out_data(fifo_data)
  );

  // Pin drive from the first data fall; the host may drive lane zero until then
  wire [3:0] oe = (selected && !paused && lanes_on) ? lane_mask(lane) : 4'h0;
  assign si_oe = oe[0];
  assign so_oe = oe[1];
  assign wp_n_oe = oe[2];
  assign hold_n_oe = oe[3];
  assign si_out = lane_out[0];
  assign so_out = lane_out[1];
  assign wp_n_out = lane_out[2];
  assign hold_n_out = lane_out[3];

  // Standby only when deselected and no internal cycle runs; pause has no say
  assign standby = !selected && !engine_busy;
  assign wp_level = sync2[3];
  assign link_paused = paused;

  // Output pin floats whenever deselected
  a_idle_float: assert property (@(posedge mclk) disable iff (!rst_n)
    !selected |-> (oe == 4'h0))
    else $error("pins driven while deselected");

  // No byte reported from a deselected link
  a_idle_no_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    (!selected && $past(!selected)) |=> !rx_valid)
    else $error("byte captured while deselected");

  // Standby held off by a running cycle
  a_standby_waits: assert property (@(posedge mclk) disable iff (!rst_n)
    engine_busy |-> !standby)
    else $error("standby during internal cycle");

  // Bit counter moves only on a rising edge or deselect
  a_count_on_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(bit_cnt) |-> ($past(sck_rise) || $past(!selected)))
    else $error("bit counter moved off a rising edge");

  // Output lanes change only after a falling edge
  a_out_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(lane_out) |-> $past(sck_fall))
    else $error("read data changed off a falling edge");

  // Input pin never driven while bits are taken in
  a_single_input: assert property (@(posedge mclk) disable iff (!rst_n)
    (phase != PH_OUT) |-> !si_oe)
    else $error("input pin driven outside data phase");
  // Dual read drives exactly lanes zero and one
  a_dual_lanes: assert property (@(posedge mclk) disable iff (!rst_n)
    (selected && !paused && lanes_on && lane == LANE_TWO) |-> (oe == 4'h3))
    else $error("dual read lane enables wrong");
  // Quad read drives all four lanes including lane zero
  a_quad_lanes: assert property (@(posedge mclk) disable iff (!rst_n)
    (selected && lanes_on && lane == LANE_FOUR) |-> (oe == 4'hf))
    else $error("quad read lane enables wrong");
  // Pause floats every lane and stops the counters
  a_pause_float: assert property (@(posedge mclk) disable iff (!rst_n)
    paused |-> (oe == 4'h0) && !sck_rise && !sck_fall)
    else $error("activity during pause");
  // Pause leaves a running cycle holding off standby
  a_pause_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    (paused && engine_busy) |-> !standby)
    else $error("pause disturbed internal cycle");
  // Every frame starts from a clean decode
  a_fresh_frame: assert property (@(posedge mclk) disable iff (!rst_n)
    !selected |=> (bit_cnt == 6'h0) && !cmd_seen && (phase == PH_IDLE))
    else $error("decode state survived deselect");
  // Data phase entered right after the lead bits of a read
  a_lead_reached: assert property (@(posedge mclk) disable iff (!rst_n)
    (selected && go_out) |=> (phase == PH_OUT) && (bit_cnt == lead))
    else $error("data phase at wrong bit count");

endmodule : flash_spi_front_end

// ===== verif/spi_host.sv
`timescale 1ns/1ps

module spi_host (
  // System clock
  input wire logic mclk,
  // Resolved pins, lane three down to lane zero
  input wire logic [3:0] io,
  // Frame and serial clock
  output logic cs_n,
  output logic sck,
  // Host side of lane zero and of the hold pin
  output logic mosi,
  output logic mosi_oe,
  output logic hold_drv_n
);
  logic idle_lvl;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    mosi_oe = 1'b0;
    hold_drv_n = 1'b1;
    idle_lvl = 1'b0;
  end

  // Half a serial clock period is four system clocks
  task automatic half_wait();
    repeat (4) @(negedge mclk);
  endtask : half_wait

  task automatic frame_start(input logic mode3);
    idle_lvl = mode3;
    sck = mode3;
    @(negedge mclk);
    cs_n = 1'b0;
    mosi_oe = 1'b1;
    half_wait();
  endtask : frame_start

  task automatic frame_end();
    sck = idle_lvl;
    half_wait();
    cs_n = 1'b1;
    mosi_oe = 1'b0;
    half_wait();
  endtask : frame_end

  // Top n bits, one a clock, data set up while the clock is low
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      mosi = b[i];
      half_wait();
      sck = 1'b1;
      half_wait();
    end
  endtask : send_bits

  // Samples just before each rise; lanes freed a clock ahead of the first fall
  task automatic read_byte(input int lanes, output logic [7:0] b);
    b = 8'h00;
    if (lanes > 1) mosi_oe = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 8 / lanes; i++) begin
      sck = 1'b0;
      half_wait();
      if (lanes == 1) b = {b[6:0], io[1]};
      else if (lanes == 2) b = {b[5:0], io[1:0]};
      else b = {b[3:0], io};
      sck = 1'b1;
      half_wait();
    end
  endtask : read_byte

  // A pause only begins with the clock low
  task automatic pause(input logic on);
    if (on) sck = 1'b0;
    @(negedge mclk);
    hold_drv_n = ~on;
    half_wait();
  endtask : pause
endmodule : spi_host

// ===== verif/test_serial_flash_spi_front_end.sv
`timescale 1ns/1ps

module test_serial_flash_spi_front_end;
  import flash_spi_pkg::*;

  typedef struct {logic [7:0] op; int lanes; logic mode3; int nb;} row_t;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic flt = 1'b0;
  logic wp_drv_n = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic engine_busy = 1'b0;
  logic cs_n, sck, mosi, mosi_oe, hold_drv_n;
  logic si_out, si_oe, so_out, so_oe, wp_n_out, wp_n_oe, hold_n_out, hold_n_oe;
  logic rx_valid, rx_is_cmd, tx_ready, standby, wp_level, link_paused;
  logic [7:0] rx_data, got;
  wire si_pin, so_pin, wp_pin, hold_pin;
  logic [7:0] rx_q[$];
  logic cmd_q[$];
  int err_count = 0;
  int n_checks = 0;
  row_t rows[4] = '{'{8'h03, 1, 1'b0, 16}, '{8'h0b, 1, 1'b1, 3},
                    '{8'h3b, 2, 1'b0, 4}, '{8'h6b, 4, 1'b1, 5}};

  always #20 mclk = ~mclk;

  // Undriven data lines toggle so a stale value never reads as valid
  always @(negedge mclk) flt <= ~flt;
  assign si_pin = si_oe ? si_out : (mosi_oe ? mosi : flt);
  assign so_pin = so_oe ? so_out : flt;
  assign wp_pin = wp_n_oe ? wp_n_out : wp_drv_n;
  assign hold_pin = hold_n_oe ? hold_n_out : hold_drv_n;

  flash_spi_front_end u_flash_spi_front_end (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si_in(si_pin), .si_out(si_out), .si_oe(si_oe),
    .so_in(so_pin), .so_out(so_out), .so_oe(so_oe),
    .wp_n_in(wp_pin), .wp_n_out(wp_n_out), .wp_n_oe(wp_n_oe),
    .hold_n_in(hold_pin), .hold_n_out(hold_n_out), .hold_n_oe(hold_n_oe),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_is_cmd(rx_is_cmd),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .engine_busy(engine_busy), .standby(standby), .wp_level(wp_level),
    .link_paused(link_paused)
  );

  spi_host u_spi_host (
    .mclk(mclk), .io({hold_pin, wp_pin, so_pin, si_pin}), .cs_n(cs_n), .sck(sck),
    .mosi(mosi), .mosi_oe(mosi_oe), .hold_drv_n(hold_drv_n)
  );

  // Received byte log
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_data);
      cmd_q.push_back(rx_is_cmd);
    end
  end

  // Both parties driving lane zero at once
  always @(posedge mclk) begin
    if (si_oe === 1'b1 && mosi_oe === 1'b1) begin
      $display("[FAIL] lane zero contention expected 0 seen 1");
      err_count++;
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic push(input logic [7:0] d);
    chk("tx_ready", 8'h01, {7'h00, tx_ready});
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge mclk);
    // Idle cycle so a following push never lowers and raises valid at once
    tx_valid = 1'b0;
    @(negedge mclk);
  endtask : push

  // Bounded wait for every lane to float after deselect
  task automatic wait_idle();
    int n;
    n = 0;
    while ((si_oe | so_oe | wp_n_oe | hold_n_oe) !== 1'b0 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk("lane enables", 8'h00, {4'h0, si_oe, so_oe, wp_n_oe, hold_n_oe});
  endtask : wait_idle

  // Watchdog against a hung link
  initial begin
    #4000000;
    $display("[FAIL] watchdog expected done seen hang");
    err_count++;
    test_done();
  end

  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    chk("standby", 8'h01, {7'h00, standby});
    chk("so_oe", 8'h00, {7'h00, so_oe});
    $display("reset test done");
    repeat (3) @(negedge mclk);
    // Reads in every lane width and both clock modes
    foreach (rows[r]) begin
      rx_q.delete();
      cmd_q.delete();
      for (int k = 0; k < rows[r].nb; k++) push(8'(rows[r].op + 8'(k * 37)));
      if (rows[r].nb == 16) chk("tx_ready full", 8'h00, {7'h00, tx_ready});
      u_spi_host.frame_start(rows[r].mode3);
      u_spi_host.send_bits(rows[r].op, 8);
      for (int k = 0; k < 3; k++) u_spi_host.send_bits(8'(8'h10 * r + k), 8);
      if (rows[r].op != 8'h03) u_spi_host.send_bits(8'h00, 8);
      chk("cmd byte", rows[r].op, rx_q[0]);
      chk("addr byte", 8'(8'h10 * r + 2), rx_q[3]);
      chk("cmd flags", 8'h02, {6'h00, cmd_q[0], cmd_q[1]});
      for (int k = 0; k <= rows[r].nb; k++) begin
        u_spi_host.read_byte(rows[r].lanes, got);
        chk("read byte", k < rows[r].nb ? 8'(rows[r].op + 8'(k * 37)) : 8'hff, got);
        if (k == 0) begin
          chk("si_oe", 8'(rows[r].lanes > 1), {7'h00, si_oe});
          chk("so_oe", 8'h01, {7'h00, so_oe});
          chk("quad oe", 8'(rows[r].lanes == 4) * 8'h03, {6'h00, wp_n_oe, hold_n_oe});
        end
      end
      u_spi_host.frame_end();
      wait_idle();
      $display("row %0d done", r);
    end
    // Link traffic while deselected
    rx_q.delete();
    cmd_q.delete();
    u_spi_host.send_bits(8'ha5, 8);
    chk("rx count", 8'h00, 8'(rx_q.size()));
    chk("so_oe", 8'h00, {7'h00, so_oe});
    $display("deselect test done");
    // Non-read command, partial byte cut by deselect, then a fresh frame
    u_spi_host.frame_start(1'b0);
    u_spi_host.send_bits(8'h06, 8);
    u_spi_host.send_bits(8'h5a, 8);
    u_spi_host.send_bits(8'hff, 5);
    chk("so_oe", 8'h00, {7'h00, so_oe});
    u_spi_host.frame_end();
    u_spi_host.frame_start(1'b1);
    u_spi_host.send_bits(8'h9c, 8);
    u_spi_host.frame_end();
    chk("rx count", 8'h03, 8'(rx_q.size()));
    chk("rx byte", 8'h9c, rx_q[2]);
    chk("cmd flags", 8'h05, {5'h00, cmd_q[0], cmd_q[1], cmd_q[2]});
    $display("framing test done");
    // Pause in mid-byte with a program cycle running
    rx_q.delete();
    engine_busy = 1'b1;
    u_spi_host.frame_start(1'b0);
    u_spi_host.send_bits(8'hc3, 4);
    u_spi_host.pause(1'b1);
    chk("link_paused", 8'h01, {7'h00, link_paused});
    u_spi_host.send_bits(8'h00, 3);
    chk("so_oe", 8'h00, {7'h00, so_oe});
    u_spi_host.pause(1'b0);
    chk("link_paused", 8'h00, {7'h00, link_paused});
    u_spi_host.send_bits(8'h30, 4);
    chk("rx byte", 8'hc3, rx_q[0]);
    u_spi_host.frame_end();
    chk("standby busy", 8'h00, {7'h00, standby});
    engine_busy = 1'b0;
    wp_drv_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk("standby", 8'h01, {7'h00, standby});
    chk("wp_level", 8'h00, {7'h00, wp_level});
    $display("pause test done");
    test_done();
  end
endmodule : test_serial_flash_spi_front_end
